// file: fls_cfg.svh
`ifndef FLS_CFG_SVH
`define FLS_CFG_SVH
// parameter indices within the fixed-length group
`define FLS_IDX_PRESET 3'h0
`define FLS_IDX_ACTUAL 3'h1
`define FLS_IDX_RATIO 3'h2
`define FLS_IDX_COEFF 3'h3
`define FLS_IDX_SHAFT 3'h4
`define FLS_IDX_SLOW 3'h5
`define FLS_IDX_DEV 3'h6
// reset values
`define FLS_RST_PRESET 16'h0000
`define FLS_RST_RATIO 16'h03E8
`define FLS_RST_COEFF 16'h03E8
`define FLS_RST_SHAFT 16'h03E8
`define FLS_RST_SLOW 16'h005A
`define FLS_RST_DEV 16'h07D0
// limits
`define FLS_RATIO_MIN 16'h0001
`define FLS_COEFF_MIN 16'h0001
`define FLS_SLOW_MIN 16'h0032
`define FLS_SLOW_MAX 16'h0064
`define FLS_RATIO_MAX 16'h7530
`define FLS_COEFF_MAX 16'h03E8
`define FLS_LEN_MAX 16'hFFFF
`define FLS_PCT_FULL 32'h0000_0064
`define FLS_TENTHS 32'h0000_000A
// terminal function numbers
`define FLS_FN_SINGLE 6'h37
`define FLS_FN_PAIR_A 6'h38
`define FLS_FN_PAIR_B_LARGE 6'h39
`define FLS_FN_PAIR_B_SMALL 6'h3A
// timing
`define FLS_CLK_MHZ 200
`define FLS_TICK_US 1000
`define FLS_NOPULSE_S 30
`define FLS_TICKS_PER_S 1000
`endif

// file: fls_pkg.sv
package fls_pkg;
	typedef enum logic [2:0] {
		FLS_ST_IDLE = 3'b001,
		FLS_ST_RUN = 3'b010,
		FLS_ST_SLOW = 3'b100
	} fls_state_type;
	typedef logic [15:0] fls_word_type;
endpackage

// file: fls_divider.sv
`timescale 1ns/1ps
// iterative restoring divider, one quotient bit per cycle
module fls_divider #(
	parameter int NW = 64,
	parameter int DW = 32
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic [NW-1:0] num_i,
	input wire logic [DW-1:0] den_i,
	output logic busy_o,
	output logic done_o,
	output logic [NW-1:0] quot_o
);
	logic [NW-1:0] quot_q;
	logic [DW:0] rem_q;
	logic [DW-1:0] den_q;
	logic [$clog2(NW+1)-1:0] cnt_q;
	logic [DW:0] trial;

	assign trial = {rem_q[DW-1:0], quot_q[NW-1]} - {1'b0, den_q};

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			quot_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				quot_q <= num_i;
				rem_q <= '0;
				// zero divisor treated as one so a bad setting cannot hang
				den_q <= (den_i == '0) ? DW'(1) : den_i;
				cnt_q <= ($clog2(NW+1))'(NW);
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (!trial[DW]) begin
					rem_q <= trial;
					quot_q <= {quot_q[NW-2:0], 1'b1};
				end else begin
					rem_q <= {rem_q[DW-1:0], quot_q[NW-1]};
					quot_q <= {quot_q[NW-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == ($clog2(NW+1))'(1)) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
			end
		end
	end

	assign quot_o = quot_q;
endmodule

// file: fls_length_stop.sv
`timescale 1ns/1ps
`include "fls_cfg.svh"

module fls_length_stop import fls_pkg::*; #(
	parameter int TICK_CYCLES = `FLS_CLK_MHZ * `FLS_TICK_US,
	parameter int NOPULSE_TICKS = `FLS_NOPULSE_S * `FLS_TICKS_PER_S
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// parameter access
	input wire logic param_wr_i,
	input wire logic [2:0] param_idx_i,
	input wire fls_pkg::fls_word_type param_wdata_i,
	output fls_pkg::fls_word_type param_rdata_o,
	input wire fls_pkg::fls_word_type pulses_per_revolution_i,
	// terminals
	input wire logic model_large_i,
	input wire logic [5:0] func_a_i,
	input wire logic [5:0] func_b_i,
	input wire logic count_input_a_large_i,
	input wire logic count_input_b_large_i,
	input wire logic count_input_a_small_i,
	input wire logic count_input_b_small_i,
	input wire logic length_clear_i,
	// drive control
	input wire logic start_req_i,
	input wire logic stop_req_i,
	input wire logic freq_above_limit_i,
	output logic run_o,
	output logic slow_o,
	output logic freq_zero_o,
	output logic stop_pulse_o,
	output logic start_refused_o,
	output logic pulse_encoder_fault_o,
	input wire logic fault_clr_i,
	// retention
	input wire logic power_fail_i,
	input wire logic restore_i,
	input wire fls_pkg::fls_word_type restore_data_i,
	output logic nv_store_o,
	output fls_pkg::fls_word_type nv_data_o,
	output fls_pkg::fls_word_type actual_length_o
);
	import fls_pkg::*;

	function automatic fls_word_type clamp16(input fls_word_type v, input fls_word_type lo, input fls_word_type hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ==========================================
	// parameter store
	fls_word_type preset_length_q, length_ratio_q, length_correction_coeff_q;
	fls_word_type shaft_size_q, slowdown_point_q, stop_point_deviation_q, base_q;
	logic base_ld;
	fls_word_type base_val;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			preset_length_q <= `FLS_RST_PRESET;
			length_ratio_q <= `FLS_RST_RATIO;
			length_correction_coeff_q <= `FLS_RST_COEFF;
			shaft_size_q <= `FLS_RST_SHAFT;
			slowdown_point_q <= `FLS_RST_SLOW;
			stop_point_deviation_q <= `FLS_RST_DEV;
		end else if (param_wr_i) begin
			case (param_idx_i)
				`FLS_IDX_PRESET: preset_length_q <= param_wdata_i;
				`FLS_IDX_RATIO: length_ratio_q <= clamp16(param_wdata_i, `FLS_RATIO_MIN, `FLS_RATIO_MAX);
				`FLS_IDX_COEFF: length_correction_coeff_q <= clamp16(param_wdata_i, `FLS_COEFF_MIN, `FLS_COEFF_MAX);
				`FLS_IDX_SHAFT: shaft_size_q <= param_wdata_i;
				`FLS_IDX_SLOW: slowdown_point_q <= clamp16(param_wdata_i, `FLS_SLOW_MIN, `FLS_SLOW_MAX);
				`FLS_IDX_DEV: stop_point_deviation_q <= param_wdata_i;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			param_rdata_o <= '0;
		end else begin
			case (param_idx_i)
				`FLS_IDX_PRESET: param_rdata_o <= preset_length_q;
				`FLS_IDX_ACTUAL: param_rdata_o <= actual_length_o;
				`FLS_IDX_RATIO: param_rdata_o <= length_ratio_q;
				`FLS_IDX_COEFF: param_rdata_o <= length_correction_coeff_q;
				`FLS_IDX_SHAFT: param_rdata_o <= shaft_size_q;
				`FLS_IDX_SLOW: param_rdata_o <= slowdown_point_q;
				`FLS_IDX_DEV: param_rdata_o <= stop_point_deviation_q;
				default: param_rdata_o <= '0;
			endcase
		end
	end

	// ==========================================
	// pulse counting
	logic in_a, in_b, a_prev_q, b_prev_q, a_rise, b_rise, single_a, single_b, paired, pulse_seen;
	logic [31:0] cnt_q;
	logic [5:0] pair_b_fn;

	assign in_a = model_large_i ? count_input_a_large_i : count_input_a_small_i;
	assign in_b = model_large_i ? count_input_b_large_i : count_input_b_small_i;
	assign pair_b_fn = model_large_i ? `FLS_FN_PAIR_B_LARGE : `FLS_FN_PAIR_B_SMALL;
	assign paired = (func_a_i == `FLS_FN_PAIR_A) && (func_b_i == pair_b_fn);
	assign single_a = func_a_i == `FLS_FN_SINGLE;
	assign single_b = func_b_i == `FLS_FN_SINGLE;
	assign a_rise = in_a && !a_prev_q;
	assign b_rise = in_b && !b_prev_q;
	assign pulse_seen = (single_a && a_rise) || (single_b && b_rise) || (paired && a_rise);
	assign base_ld = length_clear_i || restore_i || (param_wr_i && param_idx_i == `FLS_IDX_ACTUAL);
	assign base_val = length_clear_i ? '0 : (restore_i ? restore_data_i : param_wdata_i);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
			cnt_q <= '0;
			base_q <= '0;
		end else begin
			a_prev_q <= in_a;
			b_prev_q <= in_b;
			if (base_ld) begin
				// clear holds while the terminal is active
				cnt_q <= '0;
				base_q <= base_val;
			end else if (paired && a_rise && in_b) begin
				cnt_q <= (cnt_q == '0) ? '0 : cnt_q - 1'b1;
			end else if (pulse_seen && cnt_q != '1) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// ==========================================
	// length arithmetic: count*perimeter(0.1mm)*ratio / (ppr*10*coeff)
	logic div_busy, div_done, div_stale_q;
	logic [63:0] div_num, div_quot;
	logic [31:0] div_den;
	logic [16:0] len_sum;

	assign div_num = cnt_q * 64'(shaft_size_q) * 64'(length_ratio_q);
	assign div_den = 32'(pulses_per_revolution_i) * `FLS_TENTHS * 32'(length_correction_coeff_q);
	assign len_sum = (div_quot > 64'(`FLS_LEN_MAX)) ? 17'h1FFFF : 17'(base_q) + 17'(div_quot[15:0]);

	fls_divider #(.NW(64), .DW(32)) u_div (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(!div_busy && !base_ld),
		.num_i(div_num),
		.den_i(div_den),
		.busy_o(div_busy),
		.done_o(div_done),
		.quot_o(div_quot)
	);

	// a division begun before a reload carries the old count, so its result is dropped
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_stale_q <= 1'b0;
		end else if (base_ld && div_busy) begin
			div_stale_q <= 1'b1;
		end else if (div_done) begin
			div_stale_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			actual_length_o <= '0;
		end else if (base_ld) begin
			actual_length_o <= base_val;
		end else if (div_done && !div_stale_q) begin
			actual_length_o <= len_sum[16] ? `FLS_LEN_MAX : len_sum[15:0];
		end
	end

	// ==========================================
	// targets; deviation offset removed in 0.1mm units
	logic signed [23:0] dev10, tgt10, act10;
	logic [31:0] act_pct, slow_pct;
	logic fixed_en, reached, near, can_start;

	assign dev10 = 24'(stop_point_deviation_q) - 24'(`FLS_RST_DEV);
	assign tgt10 = 24'(preset_length_q) * 24'(`FLS_TENTHS) + dev10;
	assign act10 = 24'(actual_length_o) * 24'(`FLS_TENTHS);
	assign act_pct = 32'(actual_length_o) * `FLS_PCT_FULL;
	assign slow_pct = 32'(preset_length_q) * 32'(slowdown_point_q);
	assign fixed_en = preset_length_q != '0;
	assign reached = fixed_en && (act10 >= tgt10);
	assign near = fixed_en && (act_pct >= slow_pct);
	assign can_start = !fixed_en || (preset_length_q > actual_length_o);

	// ==========================================
	// run control
	fls_state_type state_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= FLS_ST_IDLE;
			stop_pulse_o <= 1'b0;
			start_refused_o <= 1'b0;
		end else begin
			stop_pulse_o <= 1'b0;
			start_refused_o <= 1'b0;
			case (state_q)
				FLS_ST_IDLE: begin
					if (start_req_i && can_start) begin
						state_q <= FLS_ST_RUN;
					end else if (start_req_i) begin
						start_refused_o <= 1'b1;
					end
				end
				FLS_ST_RUN, FLS_ST_SLOW: begin
					if (stop_req_i || reached) begin
						state_q <= FLS_ST_IDLE;
						stop_pulse_o <= reached;
					end else if (near) begin
						state_q <= FLS_ST_SLOW;
					end
				end
				default: state_q <= FLS_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_o <= 1'b0;
			slow_o <= 1'b0;
			freq_zero_o <= 1'b1;
		end else begin
			run_o <= state_q != FLS_ST_IDLE;
			slow_o <= state_q == FLS_ST_SLOW;
			freq_zero_o <= state_q == FLS_ST_IDLE;
		end
	end

	// ==========================================
	// missing-pulse watchdog on a 1 ms tick
	logic [$clog2(TICK_CYCLES)-1:0] div_cnt_q;
	logic [$clog2(NOPULSE_TICKS+1)-1:0] np_cnt_q;
	logic tick_q, watch;

	assign watch = run_o && freq_above_limit_i && actual_length_o == '0 && !pulse_seen;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			// wrap on the compare itself, else the period grows by one cycle
			tick_q <= div_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
			div_cnt_q <= (div_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) ? '0 : div_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			np_cnt_q <= '0;
			pulse_encoder_fault_o <= 1'b0;
		end else begin
			if (!watch) begin
				np_cnt_q <= '0;
			end else if (tick_q && np_cnt_q != ($clog2(NOPULSE_TICKS+1))'(NOPULSE_TICKS)) begin
				np_cnt_q <= np_cnt_q + 1'b1;
			end
			// a new fault wins over a clear in the same cycle
			if (watch && np_cnt_q == ($clog2(NOPULSE_TICKS+1))'(NOPULSE_TICKS)) begin
				pulse_encoder_fault_o <= 1'b1;
			end else if (fault_clr_i) begin
				pulse_encoder_fault_o <= 1'b0;
			end
		end
	end

	// ==========================================
	// retention store at power-off
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			nv_store_o <= 1'b0;
			nv_data_o <= '0;
		end else begin
			nv_store_o <= power_fail_i;
			if (power_fail_i) begin
				nv_data_o <= actual_length_o;
			end
		end
	end

	// ==========================================
	// checks
	sequence start_refused_s;
		start_req_i && state_q == FLS_ST_IDLE && !can_start;
	endsequence
	sequence running_s;
		state_q != FLS_ST_IDLE;
	endsequence

	property refuse_p;
		@(posedge clock_i) disable iff (!rstn_i) start_refused_s |=> start_refused_o && !run_o ##1 !run_o;
	endproperty
	property stop_p;
		@(posedge clock_i) disable iff (!rstn_i) running_s and reached |=> stop_pulse_o ##1 freq_zero_o && !run_o;
	endproperty

	refuse_start_a: assert property (refuse_p) else $error("start accepted without margin");
	stop_at_len_a: assert property (stop_p) else $error("no stop at preset length");
	slow_point_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		state_q == FLS_ST_RUN && near && !reached && !stop_req_i |=> ##1 slow_o)
		else $error("no slowdown near preset");
	zero_preset_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		preset_length_q == '0 |=> !stop_pulse_o)
		else $error("fixed stop while disabled");
	clear_len_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		length_clear_i |=> actual_length_o == '0 && cnt_q == '0)
		else $error("clear did not zero length");
	nv_store_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		power_fail_i |=> nv_store_o && nv_data_o == $past(actual_length_o))
		else $error("length not stored at power-off");
	fault_cause_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		$rose(pulse_encoder_fault_o) |-> $past(watch) && $past(np_cnt_q) == ($clog2(NOPULSE_TICKS+1))'(NOPULSE_TICKS))
		else $error("fault without pulse timeout");
	dev_offset_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		fixed_en && stop_point_deviation_q == `FLS_RST_DEV && actual_length_o >= preset_length_q |-> reached)
		else $error("deviation offset wrong");
	len_sat_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		div_done && !div_stale_q && !base_ld
		&& (div_quot > 64'(`FLS_LEN_MAX) || 17'(base_q) + 17'(div_quot[15:0]) > 17'(`FLS_LEN_MAX))
		|=> actual_length_o == `FLS_LEN_MAX)
		else $error("length wrapped");
	single_cnt_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
		single_a && !paired && a_rise && !base_ld && cnt_q != '1 |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("single count missed");
endmodule

// file: fls_encoder_model.sv
`timescale 1ns/1ps
// ==========
// pulse encoder on the counting terminals
module fls_encoder_model (
	input wire logic clock_i,
	output logic phase_a_o,
	output logic phase_b_o
);
	initial begin
		phase_a_o = 1'b0;
		phase_b_o = 1'b0;
	end
	// b settles before a rises, so the direction sampled on the a edge is never ambiguous
	// half sets the phase width: 2 is prompt, larger values are slow
	task automatic pulses(input int n, input logic down, input int half);
		for (int i = 0; i < n; i++) begin
			@(posedge clock_i) phase_b_o <= down;
			repeat (half) @(posedge clock_i);
			phase_a_o <= 1'b1;
			repeat (half) @(posedge clock_i);
			phase_a_o <= 1'b0;
			repeat (half) @(posedge clock_i);
			phase_b_o <= 1'b0;
		end
	endtask
endmodule

// file: fls_length_stop_test.sv
`timescale 1ns/1ps
`include "fls_cfg.svh"
// ==========
// bench for the fixed-length stop block
module fls_length_stop_test;
	import fls_pkg::*;
	logic clock_i, rstn_i, param_wr_i, model_large_i, length_clear_i, start_req_i, stop_req_i;
	logic freq_above_limit_i, fault_clr_i, power_fail_i, restore_i, enc_a, enc_b, refused, running;
	logic run_o, slow_o, freq_zero_o, stop_pulse_o, start_refused_o, pulse_encoder_fault_o, nv_store_o;
	logic [2:0] param_idx_i;
	logic [5:0] func_a_i, func_b_i;
	fls_word_type param_wdata_i, restore_data_i, param_rdata_o, nv_data_o, actual_length_o, nv_last;
	int err_count = 0, n_checks = 0, cycles = 0, stops = 0, stores = 0, s;
	fls_word_type rst_tab [8] = '{`FLS_RST_PRESET, 16'h0000, `FLS_RST_RATIO, `FLS_RST_COEFF,
		`FLS_RST_SHAFT, `FLS_RST_SLOW, `FLS_RST_DEV, 16'h0000};

	// short tick and timeout so the no-pulse fault fits the run
	fls_length_stop #(.TICK_CYCLES(10), .NOPULSE_TICKS(5)) dut (.clock_i(clock_i), .rstn_i(rstn_i),
		.param_wr_i(param_wr_i), .param_idx_i(param_idx_i), .param_wdata_i(param_wdata_i),
		.param_rdata_o(param_rdata_o), .pulses_per_revolution_i(16'h000A), .model_large_i(model_large_i),
		.func_a_i(func_a_i), .func_b_i(func_b_i), .count_input_a_large_i(enc_a), .count_input_b_large_i(enc_b),
		.count_input_a_small_i(enc_a), .count_input_b_small_i(enc_b), .length_clear_i(length_clear_i),
		.start_req_i(start_req_i), .stop_req_i(stop_req_i), .freq_above_limit_i(freq_above_limit_i),
		.run_o(run_o), .slow_o(slow_o), .freq_zero_o(freq_zero_o), .stop_pulse_o(stop_pulse_o),
		.start_refused_o(start_refused_o), .pulse_encoder_fault_o(pulse_encoder_fault_o),
		.fault_clr_i(fault_clr_i), .power_fail_i(power_fail_i), .restore_i(restore_i),
		.restore_data_i(restore_data_i), .nv_store_o(nv_store_o), .nv_data_o(nv_data_o),
		.actual_length_o(actual_length_o));
	fls_encoder_model enc (.clock_i(clock_i), .phase_a_o(enc_a), .phase_b_o(enc_b));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		cycles++;
		if (stop_pulse_o === 1'b1) stops++;
		if (nv_store_o === 1'b1) begin
			stores++;
			nv_last = nv_data_o;
		end
		if (cycles == 30000) begin
			err_count++;
			final_report();
		end
	end

	// ==========
	// access tasks
	task automatic check(input string what, input fls_word_type seen, input fls_word_type exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] idx, input fls_word_type data);
		@(posedge clock_i);
		param_wr_i <= 1'b1;
		param_idx_i <= idx;
		param_wdata_i <= data;
		@(posedge clock_i);
		param_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] idx, input fls_word_type exp);
		@(posedge clock_i);
		param_idx_i <= idx;
		repeat (3) @(posedge clock_i);
		#1 check("param", param_rdata_o, exp);
	endtask
	// 10 pulses per turn on a 100 mm perimeter: 10 mm a pulse at unit ratio
	task automatic cnt(input int n, input logic down, input fls_word_type exp);
		enc.pulses(n, down, 2);
		repeat (140) @(posedge clock_i);
		#1 check("length", actual_length_o, exp);
	endtask
	task automatic clr();
		@(posedge clock_i) length_clear_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		length_clear_i <= 1'b0;
		repeat (140) @(posedge clock_i);
	endtask
	task automatic start();
		@(posedge clock_i) start_req_i <= 1'b1;
		@(posedge clock_i) start_req_i <= 1'b0;
		// the refusal pulse stands only in the cycle after the request
		#1 refused = start_refused_o;
		repeat (2) @(posedge clock_i);
		#1 running = run_o;
	endtask
	task automatic stop_now();
		@(posedge clock_i) stop_req_i <= 1'b1;
		@(posedge clock_i) stop_req_i <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========
	// main sequence
	initial begin
		{rstn_i, param_wr_i, length_clear_i, start_req_i, stop_req_i} = 5'b00000;
		{freq_above_limit_i, fault_clr_i, power_fail_i, restore_i} = 4'b0000;
		param_idx_i = 3'h0;
		param_wdata_i = 16'h0000;
		restore_data_i = 16'h0000;
		model_large_i = 1'b1;
		func_a_i = `FLS_FN_SINGLE;
		func_b_i = 6'h00;
		repeat (8) @(posedge clock_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 8; i++) rd(3'(i), rst_tab[i]);
		check("idle", {15'h0000, freq_zero_o}, 16'h0001);
		wr(`FLS_IDX_SLOW, 16'h001E);
		rd(`FLS_IDX_SLOW, `FLS_SLOW_MIN);
		wr(`FLS_IDX_SLOW, 16'h0065);
		rd(`FLS_IDX_SLOW, `FLS_SLOW_MAX);
		wr(`FLS_IDX_SLOW, `FLS_RST_SLOW);
		cnt(5, 1'b0, 16'h0032);
		wr(`FLS_IDX_RATIO, 16'h07D0);
		clr();
		cnt(3, 1'b0, 16'h003C);
		wr(`FLS_IDX_COEFF, 16'h01F4);
		clr();
		cnt(1, 1'b0, 16'h0028);
		wr(`FLS_IDX_RATIO, `FLS_RST_RATIO);
		wr(`FLS_IDX_COEFF, `FLS_RST_COEFF);
		@(posedge clock_i);
		func_a_i <= `FLS_FN_PAIR_A;
		func_b_i <= `FLS_FN_PAIR_B_LARGE;
		clr();
		cnt(3, 1'b0, 16'h001E);
		cnt(1, 1'b1, 16'h0014);
		@(posedge clock_i);
		model_large_i <= 1'b0;
		func_b_i <= `FLS_FN_PAIR_B_SMALL;
		clr();
		cnt(2, 1'b0, 16'h0014);
		cnt(1, 1'b1, 16'h000A);
		@(posedge clock_i);
		model_large_i <= 1'b1;
		func_a_i <= `FLS_FN_SINGLE;
		// pulses while the clear terminal is held must be lost
		@(posedge clock_i) length_clear_i <= 1'b1;
		enc.pulses(2, 1'b0, 6);
		repeat (140) @(posedge clock_i);
		length_clear_i <= 1'b0;
		#1 check("cleared", actual_length_o, 16'h0000);
		cnt(1, 1'b0, 16'h000A);
		// single-counter function on the second terminal
		@(posedge clock_i);
		func_a_i <= 6'h00;
		func_b_i <= `FLS_FN_SINGLE;
		cnt(2, 1'b1, 16'h001E);
		@(posedge clock_i);
		func_a_i <= `FLS_FN_SINGLE;
		func_b_i <= 6'h00;
		clr();
		wr(`FLS_IDX_PRESET, 16'h0064);
		start();
		check("run", {15'h0000, running}, 16'h0001);
		check("freq", {15'h0000, freq_zero_o}, 16'h0000);
		cnt(8, 1'b0, 16'h0050);
		check("slow", {15'h0000, slow_o}, 16'h0000);
		cnt(1, 1'b0, 16'h005A);
		check("slow", {15'h0000, slow_o}, 16'h0001);
		s = stops;
		cnt(1, 1'b0, 16'h0064);
		check("stops", 16'(stops - s), 16'h0001);
		check("run", {14'h0000, run_o, freq_zero_o}, 16'h0001);
		start();
		check("refused", {14'h0000, refused, running}, 16'h0002);
		clr();
		wr(`FLS_IDX_DEV, 16'h076C);
		start();
		s = stops;
		cnt(9, 1'b0, 16'h005A);
		check("early stop", {15'h0000, run_o}, 16'h0000);
		check("stops", 16'(stops - s), 16'h0001);
		wr(`FLS_IDX_DEV, `FLS_RST_DEV);
		clr();
		wr(`FLS_IDX_PRESET, 16'h0000);
		start();
		cnt(3, 1'b0, 16'h001E);
		check("run", {15'h0000, run_o}, 16'h0001);
		stop_now();
		check("run", {15'h0000, run_o}, 16'h0000);
		clr();
		wr(`FLS_IDX_PRESET, 16'h0064);
		start();
		@(posedge clock_i) freq_above_limit_i <= 1'b1;
		repeat (20) @(posedge clock_i);
		#1 check("fault", {15'h0000, pulse_encoder_fault_o}, 16'h0000);
		repeat (80) @(posedge clock_i);
		#1 check("fault", {15'h0000, pulse_encoder_fault_o}, 16'h0001);
		stop_now();
		freq_above_limit_i <= 1'b0;
		@(posedge clock_i) fault_clr_i <= 1'b1;
		@(posedge clock_i) fault_clr_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1 check("fault", {15'h0000, pulse_encoder_fault_o}, 16'h0000);
		wr(`FLS_IDX_ACTUAL, 16'h1234);
		@(posedge clock_i) power_fail_i <= 1'b1;
		@(posedge clock_i) power_fail_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		check("stored", nv_last, 16'h1234);
		check("stores", 16'(stores), 16'h0001);
		@(posedge clock_i) restore_i <= 1'b1;
		restore_data_i <= 16'h0042;
		@(posedge clock_i) restore_i <= 1'b0;
		repeat (140) @(posedge clock_i);
		rd(`FLS_IDX_ACTUAL, 16'h0042);
		wr(`FLS_IDX_ACTUAL, 16'hFFF0);
		cnt(5, 1'b0, `FLS_LEN_MAX);
		final_report();
	end
endmodule
